// ==== verilog/dcps_pkg.sv ====
`default_nettype none

package dcps_pkg;

  // ----------------------------------------------------------------
  // command encoding {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] DCPS_CMD_NOP  = 4'h7;
  localparam logic [3:0] DCPS_CMD_REF  = 4'h1;
  localparam logic [3:0] DCPS_CMD_MRS  = 4'h0;
  localparam logic [3:0] DCPS_CMD_ACT  = 4'h3;
  localparam logic [3:0] DCPS_CMD_PRE  = 4'h2;
  localparam logic [3:0] DCPS_CMD_WR   = 4'h4;
  localparam logic [3:0] DCPS_CMD_RD   = 4'h5;
  localparam logic [3:0] DCPS_CMD_ZQ   = 4'h6;

  // ----------------------------------------------------------------
  // timing values in ns and clock cycles, bank count
  // ----------------------------------------------------------------
  localparam int DCPS_CLK_NS      = 25;
  localparam int DCPS_EXIT_NS     = 170;
  localparam int DCPS_EXIT_CYC    = (DCPS_EXIT_NS + DCPS_CLK_NS - 1) / DCPS_CLK_NS;
  localparam int DCPS_WR_WAIT_NCK = 512;
  localparam int DCPS_BANKS       = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DCPS_ST_IDLE,
    DCPS_ST_ACTIVE,
    DCPS_ST_ACT_PD,
    DCPS_ST_PRE_PD,
    DCPS_ST_SELF_REF
  } dcps_state_e;

  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       a10;
    logic [2:0] ba;
  } dcps_cmd_s;

endpackage

`default_nettype wire

// ==== verilog/dcps_cmd_decode.sv ====
`timescale 1ns/100ps
`default_nettype none

module dcps_cmd_decode
  import dcps_pkg::*;
(
  // command pins
  input  wire dcps_cmd_s cmd,
  // decoded flags
  output logic           is_nop,
  output logic           is_ref,
  output logic           is_act,
  output logic           is_pre,
  output logic           is_rw
);

  logic [3:0] code;

  // ----------------------------------------------------------------
  // combinational decode, sampled at the CLOCK edge in dcps_top; deselect acts as no-operation
  // ----------------------------------------------------------------
  always_comb
  begin
    code   = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    is_nop = cmd.cs_n || (code == DCPS_CMD_NOP);
    is_ref = (code == DCPS_CMD_REF);
    is_act = (code == DCPS_CMD_ACT);
    is_pre = (code == DCPS_CMD_PRE);
    is_rw  = (code == DCPS_CMD_WR) || (code == DCPS_CMD_RD);
  end

endmodule

`default_nettype wire

// ==== verilog/dcps_top.sv ====
// Behaviour
// - transition from previous/current cke plus command
// - open bank plus cke drop: active powerdown
// - idle or refreshing cke drop: precharge powerdown
// - busy entry chooses by banks at completion
// - cke low held: stay, ignore commands
// - self refresh only from all idle
// - no refresh during power down
// - odt off in self refresh
// - idle needs closed, quiet, cke high, timed
// - decode command at rising edge
// - deselect equals nop, no termination
// - self-refresh exit independent of clock; code exits on cke high only at a CLOCK rising edge
`timescale 1ns/100ps
`default_nettype none

module dcps_top
  import dcps_pkg::*;
#(
  parameter int BURST_CYC = 4,
  parameter int EXIT_CYC  = DCPS_EXIT_CYC
)
(
  // clock and reset
  input  wire logic      CLOCK,
  input  wire logic      RSTN,
  // memory command pins
  input  wire logic      CKE,
  input  wire dcps_cmd_s CMD,
  input  wire logic      ODT,
  // state outputs
  output logic [2:0]     STATE,
  output logic           IDLE,
  output logic           ODT_EN,
  output logic           REFRESHING,
  output logic           CMD_ERR,
  output logic [7:0]     BANKS_OPEN
);

  // counters hold these ranges only; exit needs two quiet cycles
  if (BURST_CYC < 1 || BURST_CYC > 15 || EXIT_CYC < 2 || EXIT_CYC > 255)
  begin : g_param_check
    $error("dcps_top: unsupported parameter");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic is_nop, is_ref, is_act, is_pre, is_rw;

  dcps_cmd_decode u_dec (
    .cmd    (CMD),
    .is_nop (is_nop),
    .is_ref (is_ref),
    .is_act (is_act),
    .is_pre (is_pre),
    .is_rw  (is_rw)
  );

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  dcps_state_e state_q, state_d;
  logic        cke_prev_q, cke_prev_d;
  logic [7:0]  banks_q, banks_d;
  logic [3:0]  burst_q, burst_d;
  logic [7:0]  exit_q, exit_d;
  logic        err_q, err_d;
  logic        pd_pend_q, pd_pend_d;
  logic        cke_fall, cke_rise, cke_low, busy;

  always_comb
  begin
    cke_fall   = cke_prev_q && !CKE;
    cke_rise   = !cke_prev_q && CKE;
    cke_low    = !cke_prev_q && !CKE;
    busy       = (burst_q != 4'h0);
    state_d    = state_q;
    cke_prev_d = CKE;
    banks_d    = banks_q;
    burst_d    = busy ? burst_q - 4'h1 : burst_q;
    exit_d     = (exit_q != 8'h00) ? exit_q - 8'h01 : exit_q;
    err_d      = 1'b0;
    pd_pend_d  = pd_pend_q && busy;
    case (state_q)
      DCPS_ST_IDLE, DCPS_ST_ACTIVE:
      begin
        if (cke_fall)
        begin
          if (is_ref && banks_q == 8'h00 && !busy)
            state_d = DCPS_ST_SELF_REF;
          else if (busy)
            pd_pend_d = 1'b1;
          else if (banks_q != 8'h00)
            state_d = DCPS_ST_ACT_PD;
          else
            state_d = DCPS_ST_PRE_PD;
          err_d = !is_nop && !(is_ref && banks_q == 8'h00 && !busy);
        end
        else if (CKE)
        begin
          if (is_act)
          begin
            banks_d[CMD.ba] = 1'b1;
            state_d         = DCPS_ST_ACTIVE;
          end
          else if (is_pre)
          begin
            if (CMD.a10)
              banks_d = 8'h00;
            else
              banks_d[CMD.ba] = 1'b0;
            burst_d = BURST_CYC[3:0];
          end
          else if (is_rw)
          begin
            burst_d = BURST_CYC[3:0];
            if (CMD.a10)
              banks_d[CMD.ba] = 1'b0;
          end
        end
        if (pd_pend_q && !busy)
          state_d = (banks_d == 8'h00) ? DCPS_ST_PRE_PD : DCPS_ST_ACT_PD;
        else if (state_d == DCPS_ST_ACTIVE && banks_d == 8'h00)
          state_d = DCPS_ST_IDLE;
      end
      DCPS_ST_ACT_PD, DCPS_ST_PRE_PD:
      begin
        if (cke_rise)
        begin
          state_d = (banks_q != 8'h00) ? DCPS_ST_ACTIVE : DCPS_ST_IDLE;
          exit_d  = EXIT_CYC[7:0];
          err_d   = !is_nop;
        end
      end
      DCPS_ST_SELF_REF:
      begin
        if (CKE)
        begin
          state_d = DCPS_ST_IDLE;
          exit_d  = EXIT_CYC[7:0];
          err_d   = !is_nop;
        end
      end
      default:
        state_d = DCPS_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q    <= DCPS_ST_IDLE;
      cke_prev_q <= 1'b0;
      banks_q    <= 8'h00;
      burst_q    <= 4'h0;
      exit_q     <= 8'h00;
      err_q      <= 1'b0;
      pd_pend_q  <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cke_prev_q <= cke_prev_d;
      banks_q    <= banks_d;
      burst_q    <= burst_d;
      exit_q     <= exit_d;
      err_q      <= err_d;
      pd_pend_q  <= pd_pend_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    STATE      = state_q;
    BANKS_OPEN = banks_q;
    CMD_ERR    = err_q;
    REFRESHING = (state_q == DCPS_ST_SELF_REF);
    ODT_EN     = ODT && (state_q != DCPS_ST_SELF_REF);
    IDLE       = (state_q == DCPS_ST_IDLE) && !busy && cke_prev_q
                 && (exit_q == 8'h00);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sr_entry_idle_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_q != DCPS_ST_SELF_REF) ##1 (state_q == DCPS_ST_SELF_REF) |-> $past(banks_q) == 8'h00)
    else $error("self refresh entered with open banks");

  act_pd_entry_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_q == DCPS_ST_ACTIVE && cke_fall && is_nop && !busy) |=> state_q == DCPS_ST_ACT_PD)
    else $error("active power down not entered");

  pre_pd_entry_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_q == DCPS_ST_IDLE && cke_fall && is_nop && !busy) |=> state_q == DCPS_ST_PRE_PD)
    else $error("precharge power down not entered");

  pd_hold_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_q == DCPS_ST_PRE_PD && cke_low) |=> state_q == DCPS_ST_PRE_PD)
    else $error("power down left while cke low");

  odt_gate_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    REFRESHING |-> !ODT_EN)
    else $error("odt active in self refresh");

  idle_exit_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_q == DCPS_ST_SELF_REF && CKE) |=> !IDLE [*2])
    else $error("idle too soon after exit");

  edge_flag_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_q == DCPS_ST_PRE_PD && cke_rise && !is_nop) |=> CMD_ERR)
    else $error("illegal exit command not flagged");

  busy_entry_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    ((state_q == DCPS_ST_IDLE || state_q == DCPS_ST_ACTIVE) && cke_fall && is_nop && busy)
      |-> ##[1:16] (state_q == DCPS_ST_ACT_PD || state_q == DCPS_ST_PRE_PD))
    else $error("deferred power down lost");

endmodule

`default_nettype wire

// ==== sim/dcps_ctl_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module dcps_ctl_model
  import dcps_pkg::*;
(
  // clock
  input  wire logic      clk,
  // memory pins
  output var logic      cke,
  output var dcps_cmd_s cmd,
  output var logic      odt
);
  initial
  begin
    cke = 1'h1;
    cmd = {DCPS_CMD_NOP, 4'h0};
    odt = 1'h0;
  end

  // one command per edge, held until the next call
  task automatic drive(input logic k, input logic [3:0] c, input logic a10, input logic [2:0] ba);
    @(posedge clk);
    #2;
    cke = k;
    cmd = {c, a10, ba};
  endtask

  task automatic idle(input int n);
    repeat (n) drive(cke, DCPS_CMD_NOP, 1'h0, 3'h0);
  endtask
endmodule

`default_nettype wire

// ==== sim/test_dram_cke_power_state_control.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end

module test_dram_cke_power_state_control;
  import dcps_pkg::*;
  localparam int EXIT = 2;
  localparam int BURST = 4;
  logic       clock;
  logic       rstn;
  logic       cke;
  dcps_cmd_s  cmd;
  logic       odt;
  logic [2:0] state;
  logic       idle;
  logic       odt_en;
  logic       refreshing;
  logic       cmd_err;
  logic [7:0] banks;
  int         num_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;

  dcps_ctl_model ctl (.clk(clock), .cke(cke), .cmd(cmd), .odt(odt));
  dcps_top #(.BURST_CYC(BURST), .EXIT_CYC(EXIT)) dut (.CLOCK(clock), .RSTN(rstn), .CKE(cke), .CMD(cmd),
    .ODT(odt), .STATE(state), .IDLE(idle), .ODT_EN(odt_en), .REFRESHING(refreshing), .CMD_ERR(cmd_err),
    .BANKS_OPEN(banks));

  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task automatic wait_state(input logic [2:0] s, input int n);
    int i;
    i = 0;
    while (i < n && state !== s)
    begin
      @(posedge clock);
      #1;
      i++;
    end
  endtask

  task automatic pd_idle();
    ctl.drive(1'h0, DCPS_CMD_NOP, 1'h0, 3'h0);
    wait_state(DCPS_ST_PRE_PD, 4);
    `CHK(state, DCPS_ST_PRE_PD)
    ctl.drive(1'h0, DCPS_CMD_ACT, 1'h0, 3'h5);
    ctl.drive(1'h0, DCPS_CMD_ACT, 1'h0, 3'h6);
    ctl.idle(2);
    `CHK(state, DCPS_ST_PRE_PD)
    `CHK(banks, 8'h00)
    `CHK(cmd_err, 1'h0)
    ctl.drive(1'h1, DCPS_CMD_NOP, 1'h0, 3'h0);
    wait_state(DCPS_ST_IDLE, 4);
    `CHK(state, DCPS_ST_IDLE)
    `CHK(idle, 1'h0)
    ctl.idle(EXIT + 3);
    `CHK(idle, 1'h1)
  endtask

  task automatic pd_active();
    ctl.drive(1'h1, DCPS_CMD_ACT, 1'h0, 3'h2);
    ctl.idle(2);
    `CHK(banks, 8'h04)
    `CHK(state, DCPS_ST_ACTIVE)
    ctl.drive(1'h0, 4'hF, 1'h0, 3'h0);
    wait_state(DCPS_ST_ACT_PD, 4);
    `CHK(state, DCPS_ST_ACT_PD)
    ctl.drive(1'h1, 4'hF, 1'h0, 3'h0);
    wait_state(DCPS_ST_ACTIVE, 4);
    `CHK(state, DCPS_ST_ACTIVE)
    `CHK(banks, 8'h04)
  endtask

  task automatic pd_busy();
    ctl.drive(1'h1, DCPS_CMD_RD, 1'h1, 3'h2);
    ctl.drive(1'h0, DCPS_CMD_NOP, 1'h0, 3'h0);
    wait_state(DCPS_ST_PRE_PD, BURST + 4);
    `CHK(state, DCPS_ST_PRE_PD)
    ctl.drive(1'h1, DCPS_CMD_NOP, 1'h0, 3'h0);
    wait_state(DCPS_ST_IDLE, 4);
    ctl.idle(EXIT + 3);
    `CHK(idle, 1'h1)
  endtask

  task automatic self_ref();
    ctl.odt = 1'h1;
    ctl.drive(1'h0, DCPS_CMD_REF, 1'h0, 3'h0);
    wait_state(DCPS_ST_SELF_REF, 4);
    `CHK(state, DCPS_ST_SELF_REF)
    `CHK(refreshing, 1'h1)
    `CHK(odt_en, 1'h0)
    `CHK(cmd_err, 1'h0)
    ctl.drive(1'h1, DCPS_CMD_NOP, 1'h0, 3'h0);
    wait_state(DCPS_ST_IDLE, 4);
    `CHK(state, DCPS_ST_IDLE)
    `CHK(odt_en, 1'h1)
    ctl.odt = 1'h0;
    ctl.idle(EXIT + 3);
  endtask

  task automatic pd_pre();
    ctl.drive(1'h1, DCPS_CMD_ACT, 1'h0, 3'h1);
    ctl.drive(1'h1, DCPS_CMD_ACT, 1'h0, 3'h3);
    ctl.drive(1'h1, DCPS_CMD_PRE, 1'h0, 3'h1);
    ctl.drive(1'h0, DCPS_CMD_NOP, 1'h0, 3'h0);
    wait_state(DCPS_ST_ACT_PD, BURST + 4);
    `CHK(state, DCPS_ST_ACT_PD)
    `CHK(banks, 8'h08)
    ctl.drive(1'h1, DCPS_CMD_NOP, 1'h0, 3'h0);
    wait_state(DCPS_ST_ACTIVE, 4);
    `CHK(state, DCPS_ST_ACTIVE)
    ctl.drive(1'h1, DCPS_CMD_PRE, 1'h1, 3'h0);
    ctl.idle(EXIT + 3);
    `CHK(state, DCPS_ST_IDLE)
    `CHK(banks, 8'h00)
    `CHK(idle, 1'h1)
  endtask

  task automatic mid_reset();
    ctl.drive(1'h1, DCPS_CMD_ACT, 1'h0, 3'h4);
    ctl.idle(1);
    `CHK(banks, 8'h10)
    rstn = 1'h0;
    #1;
    `CHK(state, DCPS_ST_IDLE)
    `CHK(banks, 8'h00)
    `CHK(idle, 1'h0)
    ctl.idle(2);
    rstn = 1'h1;
    ctl.idle(2);
    `CHK(idle, 1'h1)
  endtask

  task automatic bad_edge();
    ctl.drive(1'h0, DCPS_CMD_ACT, 1'h0, 3'h1);
    ctl.drive(1'h0, DCPS_CMD_NOP, 1'h0, 3'h0);
    #1;
    if (cmd_err !== 1'h1)
    begin
      @(posedge clock);
      #1;
    end
    `CHK(cmd_err, 1'h1)
    @(posedge clock);
    #1;
    `CHK(cmd_err, 1'h0)
    ctl.drive(1'h1, DCPS_CMD_ACT, 1'h0, 3'h2);
    ctl.drive(1'h1, DCPS_CMD_NOP, 1'h0, 3'h0);
    `CHK(cmd_err, 1'h1)
    `CHK(state, DCPS_ST_IDLE)
    @(posedge clock);
    #1;
    `CHK(cmd_err, 1'h0)
    `CHK(banks, 8'h00)
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end

  initial
  begin
    rstn = 1'h0;
    repeat (4) @(posedge clock);
    #2;
    rstn = 1'h1;
    ctl.idle(EXIT + 3);
    pd_idle();
    pd_active();
    pd_busy();
    self_ref();
    pd_pre();
    mid_reset();
    bad_edge();
    wrap_up();
  end
endmodule

`default_nettype wire
